// File: hdl/ilg_defines.svh
`ifndef ILG_DEFINES_SVH
`define ILG_DEFINES_SVH
// Operation
// [RQ1] listener, acceptor, remote/local, clear; no talker
// [RQ2] processor handshake via ready and data-valid lines
// [RQ3] local-state line high local, low remote
// [RQ4] one-shot on local change to middle interrupt
// [RQ5] data-valid goes to highest interrupt input
// [RQ6] processor drives ready low when ready
// [RQ7] chip raises data-valid for a valid byte
// [RQ8] processor holds ready high while processing byte
// [RQ9] input buffer enabled only during byte read
// [RQ10] shift registers feed address, ton, lon, rsv, rtl
// [RQ11] load parallel while load-select high, else shift
// [RQ12] local key gives short return-to-local pulse
// [RQ13] overload trip raises request-service bit
// [RQ14] no serial or parallel poll support
// [RQ15] clear-active level to lowest interrupt input
// [RQ16] overload switch high, release delayed
// [RQ17] ready line reached through memory-mapped control
// [RQ18] ready low, valid high, read, ready high, valid low

// ----------------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------------
`define ILG_CLK_MHZ       250
`define ILG_ONESHOT_NS    1000
`define ILG_ONESHOT_CYC   ((`ILG_ONESHOT_NS * `ILG_CLK_MHZ + 999) / 1000)
`define ILG_RTL_NS        200
`define ILG_RTL_CYC       ((`ILG_RTL_NS * `ILG_CLK_MHZ + 999) / 1000)
`define ILG_OVL_HOLD_NS   10000
`define ILG_OVL_HOLD_CYC  ((`ILG_OVL_HOLD_NS * `ILG_CLK_MHZ + 999) / 1000)
`define ILG_BUF_SETTLE    3'h4

// ----------------------------------------------------------------------
// register map
// ----------------------------------------------------------------------
`define ILG_OFS_CTRL      8'h00
`define ILG_OFS_ADDR      8'h04
`define ILG_OFS_DATA      8'h08
`define ILG_OFS_STAT      8'h0C
`define ILG_OFS_ISTAT     8'h10
`define ILG_OFS_ICLR      8'h14
`define ILG_OFS_IEN       8'h18

// ----------------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------------
`define ILG_CTRL_RDY      0
`define ILG_CTRL_LON      1
`define ILG_CTRL_RST      2'h1
`define ILG_ADDR_RST      5'h00
`define ILG_IEN_RST       4'h0
`define ILG_EVT_DVD       0
`define ILG_EVT_LOC       1
`define ILG_EVT_CLR       2
`define ILG_EVT_OVL       3
`define ILG_SR_W          8
`define ILG_RESP_OKAY     2'h0
`define ILG_RESP_SLVERR   2'h2

`endif

// File: hdl/ilg_pkg.sv
package ilg_pkg;

    // listener chip and instrument pins, all asynchronous to clk_sys
    typedef struct packed {
        logic       loc;
        logic       dvd;
        logic       clr;
        logic       load_sel;
        logic       shift_clk;
        logic       overload;
        logic       local_key;
        logic [7:0] dio;
    } ilg_pins_s;

    // processor interrupt lines by priority
    typedef struct packed {
        logic high;
        logic mid;
        logic low;
    } ilg_irq_s;

    typedef logic [3:0] ilg_evt_t;

endpackage : ilg_pkg

// File: hdl/ilg_oneshot.sv
`timescale 1ns/1ps

module ilg_oneshot #(
    parameter int unsigned LEN = 250,
    parameter int unsigned CW  = $clog2(LEN + 1)
) (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic rst,
    // trigger and pulse
    input  wire logic trig,
    output logic      pulse_r
);

    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    logic          pulse_nxt;

    // retrigger restarts the full width
    always_comb
    begin
        cnt_nxt = cnt_r;
        if (trig)
            cnt_nxt = CW'(LEN);
        else if (cnt_r != '0)
            cnt_nxt = cnt_r - 1'b1;
        pulse_nxt = (cnt_nxt != '0);
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            cnt_r   <= '0;
            pulse_r <= 1'b0;
        end
        else
        begin
            cnt_r   <= cnt_nxt;
            pulse_r <= pulse_nxt;
        end
    end

endmodule : ilg_oneshot

// File: hdl/ilg_status_shift.sv
`timescale 1ns/1ps

module ilg_status_shift #(
    parameter int unsigned W = 8
) (
    // clock and reset
    input  wire logic         clk_sys,
    input  wire logic         rst,
    // control from the listener chip
    input  wire logic         load_sel,
    input  wire logic         shift_en,
    // data
    input  wire logic [W-1:0] par_in,
    input  wire logic         ser_in,
    output logic              ser_out
);

    logic [W-1:0] sh_r;
    logic [W-1:0] sh_nxt;

    always_comb
    begin
        sh_nxt = sh_r;
        if (load_sel)
            sh_nxt = par_in;                     // [RQ11]
        else if (shift_en)
            sh_nxt = {sh_r[W-2:0], ser_in};      // [RQ11]
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
            sh_r <= '0;
        else
            sh_r <= sh_nxt;
    end

    // msb leaves first
    assign ser_out = sh_r[W-1];

endmodule : ilg_status_shift

// File: hdl/ilg_glue.sv
// Design decisions made here: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`include "ilg_defines.svh"

module ilg_glue #(
    parameter int unsigned ONESHOT_LEN = `ILG_ONESHOT_CYC,
    parameter int unsigned RTL_LEN     = `ILG_RTL_CYC,
    parameter int unsigned OVL_HOLD    = `ILG_OVL_HOLD_CYC
) (
    // clock and reset
    input  wire logic               clk_sys,
    input  wire logic               rst,
    // axi4-lite write channels
    input  wire logic [7:0]         s_axi_awaddr,
    input  wire logic               s_axi_awvalid,
    output logic                    s_axi_awready,
    input  wire logic [31:0]        s_axi_wdata,
    input  wire logic [3:0]         s_axi_wstrb,
    input  wire logic               s_axi_wvalid,
    output logic                    s_axi_wready,
    output logic [1:0]              s_axi_bresp,
    output logic                    s_axi_bvalid,
    input  wire logic               s_axi_bready,
    // axi4-lite read channels
    input  wire logic [7:0]         s_axi_araddr,
    input  wire logic               s_axi_arvalid,
    output logic                    s_axi_arready,
    output logic [31:0]             s_axi_rdata,
    output logic [1:0]              s_axi_rresp,
    output logic                    s_axi_rvalid,
    input  wire logic               s_axi_rready,
    // listener chip side
    input  wire ilg_pkg::ilg_pins_s chip_pins,
    output logic                    proc_ready_n,
    output logic                    serial_status_in,
    output logic                    bus_input_buffer_en,
    // processor interrupts and attenuator
    output ilg_pkg::ilg_irq_s       irq_cpu,
    output logic                    irq,
    output logic                    ovl_switch
);

    localparam int unsigned OCW = $clog2(OVL_HOLD + 1);

    // ------------------------------------------------------------------
    // pin synchronisers and edge detect
    // ------------------------------------------------------------------
    ilg_pkg::ilg_pins_s s1_r;
    ilg_pkg::ilg_pins_s s2_r;
    ilg_pkg::ilg_pins_s prev_r;

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            s1_r   <= '0;
            s2_r   <= '0;
            prev_r <= '0;
        end
        else
        begin
            s1_r   <= chip_pins;
            s2_r   <= s1_r;
            prev_r <= s2_r;
        end
    end

    logic loc_chg;
    logic key_rise;
    logic shift_en;
    logic loc_pulse;
    logic rtl_pulse;

    assign loc_chg  = s2_r.loc ^ prev_r.loc;
    assign key_rise = s2_r.local_key & ~prev_r.local_key;
    assign shift_en = s2_r.shift_clk & ~prev_r.shift_clk;

    // local/remote change interrupt pulse
    ilg_oneshot #(.LEN(ONESHOT_LEN)) local_change_oneshot (
        .clk_sys (clk_sys),
        .rst     (rst),
        .trig    (loc_chg),                       // [RQ4]
        .pulse_r (loc_pulse)
    );

    // return-to-local pulse from the front-panel key
    ilg_oneshot #(.LEN(RTL_LEN)) rtl_oneshot (
        .clk_sys (clk_sys),
        .rst     (rst),
        .trig    (key_rise),                      // [RQ12]
        .pulse_r (rtl_pulse)
    );

    // ------------------------------------------------------------------
    // register write side
    // ------------------------------------------------------------------
    logic                aw_have_r, aw_have_nxt;
    logic                w_have_r, w_have_nxt;
    logic [7:0]          awaddr_r, awaddr_nxt;
    logic [31:0]         wdata_r, wdata_nxt;
    logic [3:0]          wstrb_r, wstrb_nxt;
    logic                awready_r, awready_nxt;
    logic                wready_r, wready_nxt;
    logic                bvalid_r, bvalid_nxt;
    logic [1:0]          bresp_r, bresp_nxt;
    logic [1:0]          ctrl_r, ctrl_nxt;
    logic [4:0]          addr_r, addr_nxt;
    ilg_pkg::ilg_evt_t   ien_r, ien_nxt;
    ilg_pkg::ilg_evt_t   iclr;

    always_comb
    begin
        aw_have_nxt = aw_have_r;
        w_have_nxt  = w_have_r;
        awaddr_nxt  = awaddr_r;
        wdata_nxt   = wdata_r;
        wstrb_nxt   = wstrb_r;
        bvalid_nxt  = bvalid_r;
        bresp_nxt   = bresp_r;
        ctrl_nxt    = ctrl_r;
        addr_nxt    = addr_r;
        ien_nxt     = ien_r;
        iclr        = '0;
        if (s_axi_awvalid && awready_r)
        begin
            aw_have_nxt = 1'b1;
            awaddr_nxt  = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_r)
        begin
            w_have_nxt = 1'b1;
            wdata_nxt  = s_axi_wdata;
            wstrb_nxt  = s_axi_wstrb;
        end
        if (bvalid_r && s_axi_bready)
            bvalid_nxt = 1'b0;
        if (aw_have_nxt && w_have_nxt && !bvalid_nxt)
        begin
            aw_have_nxt = 1'b0;
            w_have_nxt  = 1'b0;
            bvalid_nxt  = 1'b1;
            bresp_nxt   = `ILG_RESP_OKAY;
            case (awaddr_nxt)
                `ILG_OFS_CTRL:
                    if (wstrb_nxt[0])
                        ctrl_nxt = wdata_nxt[1:0];    // [RQ17]
                `ILG_OFS_ADDR:
                    if (wstrb_nxt[0])
                        addr_nxt = wdata_nxt[4:0];
                `ILG_OFS_ICLR:
                    if (wstrb_nxt[0])
                        iclr = wdata_nxt[3:0];
                `ILG_OFS_IEN:
                    if (wstrb_nxt[0])
                        ien_nxt = wdata_nxt[3:0];
                `ILG_OFS_DATA,
                `ILG_OFS_STAT,
                `ILG_OFS_ISTAT: ;
                default:
                    bresp_nxt = `ILG_RESP_SLVERR;
            endcase
        end
        awready_nxt = !aw_have_nxt && !bvalid_nxt;
        wready_nxt  = !w_have_nxt && !bvalid_nxt;
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            aw_have_r <= 1'b0;
            w_have_r  <= 1'b0;
            awaddr_r  <= 8'h00;
            wdata_r   <= 32'h00000000;
            wstrb_r   <= 4'h0;
            awready_r <= 1'b0;
            wready_r  <= 1'b0;
            bvalid_r  <= 1'b0;
            bresp_r   <= `ILG_RESP_OKAY;
            ctrl_r    <= `ILG_CTRL_RST;
            addr_r    <= `ILG_ADDR_RST;
            ien_r     <= `ILG_IEN_RST;
        end
        else
        begin
            aw_have_r <= aw_have_nxt;
            w_have_r  <= w_have_nxt;
            awaddr_r  <= awaddr_nxt;
            wdata_r   <= wdata_nxt;
            wstrb_r   <= wstrb_nxt;
            awready_r <= awready_nxt;
            wready_r  <= wready_nxt;
            bvalid_r  <= bvalid_nxt;
            bresp_r   <= bresp_nxt;
            ctrl_r    <= ctrl_nxt;
            addr_r    <= addr_nxt;
            ien_r     <= ien_nxt;
        end
    end

    // ------------------------------------------------------------------
    // events, interrupts and overload hold
    // ------------------------------------------------------------------
    ilg_pkg::ilg_evt_t istat_r, istat_nxt;
    ilg_pkg::ilg_evt_t evt;
    ilg_pkg::ilg_irq_s irq_cpu_r, irq_cpu_nxt;
    logic              irq_r, irq_nxt;
    logic [OCW-1:0]    ovl_cnt_r, ovl_cnt_nxt;
    logic              ovl_r, ovl_nxt;

    always_comb
    begin
        evt                = '0;
        evt[`ILG_EVT_DVD]  = s2_r.dvd & ~prev_r.dvd;             // [RQ7]
        evt[`ILG_EVT_LOC]  = loc_chg;
        evt[`ILG_EVT_CLR]  = s2_r.clr & ~prev_r.clr;
        evt[`ILG_EVT_OVL]  = s2_r.overload & ~prev_r.overload;
        // a new event wins over a clear in the same cycle
        istat_nxt          = (istat_r & ~iclr) | evt;
        irq_nxt            = |(istat_nxt & ien_nxt);
        irq_cpu_nxt.high   = s2_r.dvd;                           // [RQ5]
        irq_cpu_nxt.mid    = loc_pulse;                          // [RQ4]
        irq_cpu_nxt.low    = s2_r.clr;                           // [RQ15]
        ovl_cnt_nxt        = ovl_cnt_r;
        if (s2_r.overload)
            ovl_cnt_nxt = OCW'(OVL_HOLD);                        // [RQ16]
        else if (ovl_cnt_r != '0)
            ovl_cnt_nxt = ovl_cnt_r - 1'b1;
        ovl_nxt            = s2_r.overload || (ovl_cnt_r != '0); // [RQ16]
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            istat_r   <= '0;
            irq_r     <= 1'b0;
            irq_cpu_r <= '0;
            ovl_cnt_r <= '0;
            ovl_r     <= 1'b0;
        end
        else
        begin
            istat_r   <= istat_nxt;
            irq_r     <= irq_nxt;
            irq_cpu_r <= irq_cpu_nxt;
            ovl_cnt_r <= ovl_cnt_nxt;
            ovl_r     <= ovl_nxt;
        end
    end

    // ------------------------------------------------------------------
    // serial status feed into the listener chip
    // ------------------------------------------------------------------
    logic                   chain;
    logic [`ILG_SR_W-1:0]   par_a;
    logic [`ILG_SR_W-1:0]   par_b;

    // talker-on is tied low: listen-only, no poll response
    assign par_a = {addr_r, 1'b0, ctrl_r[`ILG_CTRL_LON], ovl_r}; // [RQ10] [RQ1] [RQ13] [RQ14]
    assign par_b = {rtl_pulse, 7'h00};                            // [RQ10]

    ilg_status_shift #(.W(`ILG_SR_W)) status_shift_reg_b (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .load_sel (s2_r.load_sel),
        .shift_en (shift_en),
        .par_in   (par_b),
        .ser_in   (1'b0),
        .ser_out  (chain)
    );

    ilg_status_shift #(.W(`ILG_SR_W)) status_shift_reg_a (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .load_sel (s2_r.load_sel),                                // [RQ11]
        .shift_en (shift_en),
        .par_in   (par_a),
        .ser_in   (chain),
        .ser_out  (serial_status_in)
    );

    // ------------------------------------------------------------------
    // register read side
    // ------------------------------------------------------------------
    logic        arready_r, arready_nxt;
    logic        rvalid_r, rvalid_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [1:0]  rresp_r, rresp_nxt;
    logic [2:0]  rd_cnt_r, rd_cnt_nxt;
    logic        buf_en_r, buf_en_nxt;

    always_comb
    begin
        rvalid_nxt = rvalid_r;
        rdata_nxt  = rdata_r;
        rresp_nxt  = rresp_r;
        rd_cnt_nxt = rd_cnt_r;
        buf_en_nxt = buf_en_r;
        if (rvalid_r && s_axi_rready)
            rvalid_nxt = 1'b0;
        if (rd_cnt_r != 3'h0)
        begin
            rd_cnt_nxt = rd_cnt_r - 3'h1;
            if (rd_cnt_r == 3'h1)
            begin
                // byte taken only while the bus buffer is on
                rdata_nxt  = {24'h000000, s2_r.dio};              // [RQ9] [RQ18]
                rvalid_nxt = 1'b1;
                buf_en_nxt = 1'b0;
            end
        end
        else if (s_axi_arvalid && arready_r)
        begin
            rresp_nxt = `ILG_RESP_OKAY;
            rdata_nxt = 32'h00000000;
            rvalid_nxt = 1'b1;
            case (s_axi_araddr)
                `ILG_OFS_CTRL:  rdata_nxt[1:0] = ctrl_r;
                `ILG_OFS_ADDR:  rdata_nxt[4:0] = addr_r;
                `ILG_OFS_STAT:  rdata_nxt[4:0] = {ovl_r, s2_r.clr,
                                    s2_r.loc, s2_r.dvd, ctrl_r[0]}; // [RQ3]
                `ILG_OFS_ISTAT: rdata_nxt[3:0] = istat_r;
                `ILG_OFS_IEN:   rdata_nxt[3:0] = ien_r;
                `ILG_OFS_ICLR:  ;
                `ILG_OFS_DATA:
                begin
                    rvalid_nxt = 1'b0;
                    buf_en_nxt = 1'b1;                            // [RQ9]
                    rd_cnt_nxt = `ILG_BUF_SETTLE;
                end
                default:        rresp_nxt = `ILG_RESP_SLVERR;
            endcase
        end
        arready_nxt = !rvalid_nxt && (rd_cnt_nxt == 3'h0);
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            arready_r <= 1'b0;
            rvalid_r  <= 1'b0;
            rdata_r   <= 32'h00000000;
            rresp_r   <= `ILG_RESP_OKAY;
            rd_cnt_r  <= 3'h0;
            buf_en_r  <= 1'b0;
        end
        else
        begin
            arready_r <= arready_nxt;
            rvalid_r  <= rvalid_nxt;
            rdata_r   <= rdata_nxt;
            rresp_r   <= rresp_nxt;
            rd_cnt_r  <= rd_cnt_nxt;
            buf_en_r  <= buf_en_nxt;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign s_axi_awready       = awready_r;
    assign s_axi_wready        = wready_r;
    assign s_axi_bvalid        = bvalid_r;
    assign s_axi_bresp         = bresp_r;
    assign s_axi_arready       = arready_r;
    assign s_axi_rvalid        = rvalid_r;
    assign s_axi_rdata         = rdata_r;
    assign s_axi_rresp         = rresp_r;
    assign proc_ready_n        = ctrl_r[`ILG_CTRL_RDY];  // [RQ2] [RQ6] [RQ8]
    assign bus_input_buffer_en = buf_en_r;
    assign irq_cpu             = irq_cpu_r;
    assign irq                 = irq_r;
    assign ovl_switch          = ovl_r;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    chk_dvd_high_irq: assert property ( // [RQ5]
        $rose(s2_r.dvd) |=> irq_cpu.high ##1 istat_r[`ILG_EVT_DVD])
        else $error("data valid did not reach high interrupt");

    chk_loc_oneshot: assert property ( // [RQ4]
        $changed(s2_r.loc) |-> ##2 irq_cpu.mid [*8])
        else $error("local change pulse missing or short");

    chk_clr_low_irq: assert property ( // [RQ15]
        s2_r.clr |=> irq_cpu.low)
        else $error("clear active not on low interrupt");

    chk_ovl_release: assert property ( // [RQ16]
        $fell(s2_r.overload) |-> ovl_switch [*8])
        else $error("overload release not delayed");

    chk_ovl_assert: assert property ( // [RQ13]
        s2_r.overload |=> ovl_switch && ovl_r)
        else $error("overload trip did not raise switch");

    chk_sr_load: assert property ( // [RQ11]
        s2_r.load_sel |=> serial_status_in == $past(addr_r[4]))
        else $error("shift register did not load address");

    chk_rtl_pulse: assert property ( // [RQ12]
        $rose(s2_r.local_key) |=> rtl_pulse)
        else $error("return to local pulse missing");

    chk_buf_read_only: assert property ( // [RQ9]
        bus_input_buffer_en |-> rd_cnt_r != 3'h0 && !rvalid_r)
        else $error("bus buffer on outside a byte read");

    chk_irq_level: assert property (
        irq == |(istat_r & ien_r))
        else $error("interrupt output disagrees with status");

    cov_byte_read: cover property (
        buf_en_r ##[1:8] (rvalid_r && s_axi_rready));
    cov_ovl_cycle: cover property (
        $rose(ovl_switch) ##[1:1000] $fell(s2_r.overload));
    cov_irq_raise: cover property ($rose(irq));

endmodule : ilg_glue

// File: bench/ilg_chip_model.sv
`timescale 1ns/1ps

module ilg_chip_model (
    // clock
    input  wire logic       clk_sys,
    // byte handshake
    input  wire logic       proc_ready_n,
    input  wire logic       offer,
    input  wire logic [3:0] lag,
    input  wire logic [7:0] byte_in,
    output logic            dvd,
    output logic [7:0]      dio
);
    logic [3:0] wait_r;

    initial
    begin
        dvd    = 1'b0;
        dio    = 8'h00;
        wait_r = 4'h0;
    end

    always @(posedge clk_sys)
    begin
        if (!dvd && !proc_ready_n && offer)
        begin
            wait_r <= wait_r + 4'h1;
            if (wait_r >= lag)
            begin
                dvd    <= 1'b1;
                dio    <= byte_in;
                wait_r <= 4'h0;
            end
        end
        else if (dvd && proc_ready_n)
        begin
            dvd <= 1'b0;
            dio <= ~dio; // released lines lose the byte
        end
    end
endmodule : ilg_chip_model

// File: bench/ilg_glue_tb_top.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin \
    n_errors++; $display("unexpected %s exp %0h got %0h", n, e, g); end end

module ilg_glue_tb_top;
    localparam int OSL = 10;
    localparam int OVH = 12;
    logic               clk_sys, rst, s_axi_awvalid, s_axi_awready;
    logic               s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic               s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic               s_axi_rvalid, s_axi_rready, proc_ready_n;
    logic               serial_status_in, bus_input_buffer_en, irq;
    logic               ovl_switch, loc, dvd, clr, load_sel, shift_clk;
    logic               overload, local_key, offer;
    logic [7:0]         s_axi_awaddr, s_axi_araddr, dio, byte_in;
    logic [31:0]        s_axi_wdata, s_axi_rdata;
    logic [3:0]         s_axi_wstrb, lag;
    logic [1:0]         s_axi_bresp, s_axi_rresp;
    logic [15:0]        got;
    ilg_pkg::ilg_pins_s chip_pins;
    ilg_pkg::ilg_irq_s  irq_cpu;
    int                 n_errors, n_compared, mid_n, buf_n, b0, k;

    assign chip_pins = {loc, dvd, clr, load_sel, shift_clk, overload,
                        local_key, dio};

    ilg_glue #(.ONESHOT_LEN(OSL), .RTL_LEN(4), .OVL_HOLD(OVH)) u_dut (.*);

    ilg_chip_model u_chip (.clk_sys(clk_sys), .proc_ready_n(proc_ready_n),
        .offer(offer), .lag(lag), .byte_in(byte_in), .dvd(dvd), .dio(dio));

    initial
    begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys)
    begin
        if (irq_cpu.mid) mid_n <= mid_n + 1;
        if (bus_input_buffer_en) buf_n <= buf_n + 1;
    end

    task automatic report_and_stop;
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : report_and_stop

    task automatic tmo;
        n_errors++;
        $display("unexpected wait exp done got timeout");
        report_and_stop();
    endtask : tmo

    task automatic wt(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : wt

    task automatic wait_hi(input logic lvl);
        int i;
        for (i = 0; i < 40; i++)
        begin
            @(posedge clk_sys);
            if (irq_cpu.high === lvl) break;
        end
        if (i == 40) tmo();
    endtask : wait_hi

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        int i;
        @(posedge clk_sys);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        for (i = 0; i < 64; i++)
        begin
            @(posedge clk_sys);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        if (i == 64) tmo();
        `CHK("bresp", er, s_axi_bresp)
        s_axi_bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input logic [1:0] er);
        int i;
        @(posedge clk_sys);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        for (i = 0; i < 64; i++)
        begin
            @(posedge clk_sys);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        if (i == 64) tmo();
        `CHK("rdata", e, s_axi_rdata)
        `CHK("rresp", er, s_axi_rresp)
        s_axi_rready <= 1'b0;
    endtask : rd

    task automatic t_reset;
        // a write without its low strobe byte must leave the register alone
        s_axi_wstrb <= 4'h0;
        wr(8'h04, 32'h1F, 2'h0);
        s_axi_wstrb <= 4'hF;
        rd(8'h00, 32'h1, 2'h0);
        rd(8'h04, 32'h0, 2'h0);
        rd(8'h18, 32'h0, 2'h0);
        rd(8'h1C, 32'h0, 2'h2);
        wr(8'h20, 32'h1, 2'h2);
        `CHK("buf_cyc", 0, buf_n)
    endtask : t_reset

    task automatic t_byte;
        for (k = 0; k < 2; k++)
        begin
            byte_in <= (k == 0) ? 8'h5A : 8'h81;
            lag     <= (k == 0) ? 4'h0 : 4'h6;
            offer   <= 1'b1;
            b0 = buf_n;
            wr(8'h00, 32'h0, 2'h0);
            `CHK("ready_n", 1'b0, proc_ready_n)
            wait_hi(1'b1);
            rd(8'h08, {24'h0, byte_in}, 2'h0);
            `CHK("buf_cyc", b0 + 4, buf_n)
            wr(8'h00, 32'h1, 2'h0);
            wait_hi(1'b0);
            offer <= 1'b0;
            rd(8'h10, 32'h1, 2'h0);
            wr(8'h14, 32'h1, 2'h0);
            rd(8'h10, 32'h0, 2'h0);
        end
    endtask : t_byte

    task automatic t_loc;
        wr(8'h18, 32'h2, 2'h0);
        b0 = mid_n;
        loc <= 1'b1;
        wt(20);
        `CHK("mid_cyc", b0 + OSL, mid_n)
        `CHK("irq", 1'b1, irq)
        rd(8'h0C, 32'h5, 2'h0);
        wr(8'h14, 32'h2, 2'h0);
        wt(2);
        `CHK("irq", 1'b0, irq)
        loc <= 1'b0;
        wt(20);
        `CHK("mid_cyc", b0 + 2 * OSL, mid_n)
        rd(8'h0C, 32'h1, 2'h0);
        wr(8'h18, 32'h0, 2'h0);
        wt(2);
        `CHK("irq", 1'b0, irq)
        rd(8'h10, 32'h2, 2'h0);
        wr(8'h14, 32'h2, 2'h0);
    endtask : t_loc

    task automatic t_clr;
        clr <= 1'b1;
        wt(5);
        `CHK("irq_low", 1'b1, irq_cpu.low)
        rd(8'h10, 32'h4, 2'h0);
        clr <= 1'b0;
        wt(5);
        `CHK("irq_low", 1'b0, irq_cpu.low)
        wr(8'h14, 32'h4, 2'h0);
    endtask : t_clr

    task automatic t_ovl;
        overload <= 1'b1;
        wt(6);
        `CHK("ovl_sw", 1'b1, ovl_switch)
        overload <= 1'b0;
        wt(OVH);
        `CHK("ovl_sw", 1'b1, ovl_switch)
        wt(8);
        `CHK("ovl_sw", 1'b0, ovl_switch)
        rd(8'h10, 32'h8, 2'h0);
        wr(8'h14, 32'h8, 2'h0);
    endtask : t_ovl

    task automatic t_shift;
        wr(8'h04, 32'h16, 2'h0);
        wr(8'h00, 32'h3, 2'h0);
        overload <= 1'b1;
        wt(6);
        load_sel <= 1'b1;
        wt(3);
        // key press so that the last parallel load catches the rtl pulse
        local_key <= 1'b1;
        wt(3);
        load_sel  <= 1'b0;
        overload  <= 1'b0;
        local_key <= 1'b0;
        wt(6);
        for (k = 0; k < 16; k++)
        begin
            got[15-k] = serial_status_in;
            shift_clk <= 1'b1;
            wt(4);
            shift_clk <= 1'b0;
            wt(4);
        end
        `CHK("status", 16'hB380, got)
        wt(30);
        wr(8'h14, 32'h8, 2'h0);
    endtask : t_shift

    initial
    begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid,
         s_axi_rready, loc, clr, load_sel, shift_clk, overload, local_key,
         offer, s_axi_awaddr, s_axi_araddr, s_axi_wdata, lag, byte_in} = '0;
        {n_errors, n_compared, mid_n, buf_n} = '0;
        s_axi_wstrb = 4'hF;
        rst = 1'b1;
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        t_reset();
        t_byte();
        t_loc();
        t_clr();
        t_ovl();
        t_shift();
        report_and_stop();
    end
endmodule : ilg_glue_tb_top
